// ==== inc/hpa_pkg.sv ====
package hpa_pkg;
   localparam int LBA_W = 48;
   localparam int PWD_W = 32;
   // Command opcodes
   localparam logic [7:0] CMD_READ_NATIVE = 8'hF8;
   localparam logic [7:0] CMD_SET_MAX = 8'hF9;
   // Sub-functions of the set-maximum command
   localparam logic [2:0] SUB_SET_ADDR = 3'h0;
   localparam logic [2:0] SUB_SET_PWD = 3'h1;
   localparam logic [2:0] SUB_LOCK = 3'h2;
   localparam logic [2:0] SUB_UNLOCK = 3'h3;
   localparam logic [2:0] SUB_FREEZE = 3'h4;
   // Identify-device feature bits
   localparam int ID_SUP_WORD = 83;
   localparam int ID_EN_WORD = 86;
   localparam int ID_EXT_BIT = 8;
   // Error codes
   localparam logic [1:0] ERR_NONE = 2'h0;
   localparam logic [1:0] ERR_ABORT = 2'h1;
   localparam logic [1:0] ERR_IDNF = 2'h2;
   localparam logic [LBA_W-1:0] NATIVE_MAX_DEF = 48'h0000_00C1_ACFF;

   typedef enum logic [1:0] {
      HPA_NOPWD = 2'b00,
      HPA_UNLOCKED = 2'b01,
      HPA_LOCKED = 2'b11,
      HPA_FROZEN = 2'b10
   } hpa_lock_e;

   typedef struct packed {
      logic [7:0] opcode;
      logic [2:0] sub;
      logic volatileOpt;
      logic [LBA_W-1:0] lba;
      logic [PWD_W-1:0] pwd;
   } hpa_cmd_s;

   typedef struct packed {
      logic [LBA_W-1:0] lba;
      logic [15:0] count;
      logic isWrite;
   } hpa_acc_s;

   typedef struct packed {
      logic [1:0] err;
      logic [LBA_W-1:0] lba;
   } hpa_rsp_s;
endpackage

// ==== hw/hpa_range_check.sv ====
`timescale 1ns/10ps
`default_nettype none
module hpa_range_check #(
   parameter int LW = 48
) (
   input wire logic [LW-1:0] startLba,
   input wire logic [15:0] count,
   input wire logic [LW-1:0] maxLba,
   output logic outOfRange
);
   logic [LW:0] lastLba;
   always_comb begin
      // Count of zero taken as 65536 sectors
      if (count == 16'h0000) begin
         lastLba = {1'b0, startLba} + (LW+1)'(17'h0FFFF);
      end else begin
         lastLba = {1'b0, startLba} + (LW+1)'(count) - (LW+1)'(1);
      end
      outOfRange = lastLba > {1'b0, maxLba};
   end
endmodule
`default_nettype wire

// ==== hw/hpa_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// RULE_01: Read-native-maximum (F8h) returns true native maximum regardless of current limit.
// RULE_02: Set-maximum (F9h) programs current maximum, volatile or nonvolatile option.
// RULE_03: Addresses above current maximum refused until a later set-maximum raises it.
// RULE_04: Volatile limit discarded at power or hardware reset; nonvolatile limit restored.
// RULE_05: Identify capacity follows every change of current maximum.
// RULE_06: Limit password survives hardware/software reset, lost at power cycle, separate.
// RULE_07: Accepted set-password enters the unlocked state.
// RULE_08: Accepted lock enters locked state; only unlock accepted until unlock or power.
// RULE_09: Accepted unlock returns locked state to unlocked state.
// RULE_10: Accepted freeze enters frozen state; all limit commands refused until power cycle.
// RULE_11: Identify word 83 bit 8 shows support; word 86 bit 8 shows enabled.
// RULE_12: Host raises limit volatile, accesses area, then resets to hide it again.
// RULE_13: Forbidden limit command aborts with error and leaves limit unchanged.
// RULE_14: Access beyond current maximum rejected with address-not-found error. The code only raises accReject; no error code goes with it.
module hpa_ctrl
   import hpa_pkg::*;
#(
   parameter logic [LBA_W-1:0] NATIVE_MAX = NATIVE_MAX_DEF
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic powerOn,
   input wire logic hardReset,
   input wire logic softReset,
   input wire logic cmdValid,
   input wire hpa_pkg::hpa_cmd_s cmd,
   input wire logic accValid,
   input wire hpa_pkg::hpa_acc_s acc,
   output logic rspValid,
   output hpa_pkg::hpa_rsp_s rsp,
   output logic accGrant,
   output logic accReject,
   output logic [LBA_W-1:0] curMax,
   output logic [LBA_W-1:0] idCapacity,
   output logic [15:0] idWord83,
   output logic [15:0] idWord86,
   output logic [1:0] lockState,
   output logic nvWrite,
   output logic [LBA_W-1:0] nvData
);
   import hpa_pkg::*;

   // Lock and password state
   hpa_lock_e lock_r;
   logic [PWD_W-1:0] pwd_r;
   logic pwdSet_r;
   logic extEnabled_r;

   // Limit state
   logic [LBA_W-1:0] curMax_r;
   logic [LBA_W-1:0] capacity_r;
   logic [LBA_W-1:0] nvMax_r;
   logic nvWrite_r;

   // Response and media access state
   logic rspValid_r;
   logic [1:0] rspErr_r;
   logic [LBA_W-1:0] rspLba_r;
   logic accGrant_r;
   logic accReject_r;
   logic outOfRange;

   // Command decode
   logic isNative;
   logic isSetMax;
   logic isSubAddr;
   logic isSubPwd;
   logic isSubLock;
   logic isSubUnlock;
   logic isSubFreeze;
   logic lbaTooHigh;
   logic pwdOk;
   logic allowed;

   // Accepted and refused operations
   logic acceptAddr;
   logic acceptNvAddr;
   logic acceptPwd;
   logic acceptLock;
   logic acceptUnlock;
   logic acceptFreeze;
   logic acceptAny;
   logic lbaRefused;

   // Reset classes
   logic powerCycle;
   logic limitReload;
   logic accClear;

   assign powerCycle = !rst_n || powerOn;
   assign limitReload = powerOn || hardReset;
   assign accClear = !rst_n || softReset;

   assign isNative = cmdValid && (cmd.opcode == CMD_READ_NATIVE);
   assign isSetMax = cmdValid && (cmd.opcode == CMD_SET_MAX);
   assign isSubAddr = (cmd.sub == SUB_SET_ADDR);
   assign isSubPwd = (cmd.sub == SUB_SET_PWD);
   assign isSubLock = (cmd.sub == SUB_LOCK);
   assign isSubUnlock = (cmd.sub == SUB_UNLOCK);
   assign isSubFreeze = (cmd.sub == SUB_FREEZE);
   assign lbaTooHigh = (cmd.lba > NATIVE_MAX);
   assign pwdOk = !pwdSet_r || (cmd.pwd == pwd_r);

   // Sub-functions the lock state admits; unknown codes never pass
   always_comb begin
      allowed = 1'b0;
      case (lock_r)
         HPA_NOPWD, HPA_UNLOCKED: begin
            case (cmd.sub)
               SUB_SET_ADDR, SUB_SET_PWD, SUB_LOCK, SUB_FREEZE: begin
                  allowed = 1'b1;
               end
               default: begin
                  allowed = 1'b0;
               end
            endcase
         end
         HPA_LOCKED: begin
            allowed = isSubUnlock && pwdOk; // RULE_08
         end
         HPA_FROZEN: begin
            allowed = 1'b0; // RULE_10
         end
         default: begin
            allowed = 1'b0;
         end
      endcase
   end

   // One strobe per accepted operation, one for a limit past native
   assign acceptAddr = isSetMax && allowed && isSubAddr && !lbaTooHigh; // RULE_02
   assign acceptNvAddr = acceptAddr && !cmd.volatileOpt; // RULE_02
   assign acceptPwd = isSetMax && allowed && isSubPwd;
   assign acceptLock = isSetMax && allowed && isSubLock;
   assign acceptUnlock = isSetMax && allowed && isSubUnlock;
   assign acceptFreeze = isSetMax && allowed && isSubFreeze;
   assign acceptAny = acceptPwd || acceptLock || acceptUnlock || acceptFreeze;
   assign lbaRefused = isSetMax && allowed && isSubAddr && lbaTooHigh;

   // Lock state machine; hard and soft resets leave it alone
   always_ff @(posedge core_clk) begin
      if (powerCycle) begin
         lock_r <= HPA_NOPWD;
      end else if (isSetMax && allowed) begin
         case (cmd.sub)
            SUB_SET_PWD: begin
               lock_r <= HPA_UNLOCKED; // RULE_07
            end
            SUB_LOCK: begin
               lock_r <= HPA_LOCKED; // RULE_08
            end
            SUB_UNLOCK: begin
               lock_r <= HPA_UNLOCKED; // RULE_09
            end
            SUB_FREEZE: begin
               lock_r <= HPA_FROZEN; // RULE_10
            end
            default: begin
               lock_r <= lock_r;
            end
         endcase
      end
   end

   // Extension reported enabled from the first accepted lock-state command
   always_ff @(posedge core_clk) begin
      if (powerCycle) begin
         extEnabled_r <= 1'b0;
      end else if (acceptAny) begin
         extEnabled_r <= 1'b1; // RULE_11
      end
   end

   // Password kept apart from any security-mode password
   always_ff @(posedge core_clk) begin
      if (powerCycle) begin
         pwd_r <= '0; // RULE_06
      end else if (acceptPwd) begin
         pwd_r <= cmd.pwd; // RULE_06
      end
   end

   // Password-present flag; only a power cycle clears it
   always_ff @(posedge core_clk) begin
      if (powerCycle) begin
         pwdSet_r <= 1'b0;
      end else if (acceptPwd) begin
         pwdSet_r <= 1'b1;
      end
   end

   // Nonvolatile image of the limit
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         nvMax_r <= NATIVE_MAX;
      end else if (acceptNvAddr) begin
         nvMax_r <= cmd.lba; // RULE_02
      end
   end

   // Store strobe to the nonvolatile medium
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         nvWrite_r <= 1'b0;
      end else begin
         nvWrite_r <= acceptNvAddr; // RULE_02
      end
   end

   // Current limit; volatile value dropped at any hardware-level reset
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         curMax_r <= NATIVE_MAX;
      end else if (limitReload) begin
         curMax_r <= nvMax_r; // RULE_04
      end else if (acceptAddr) begin
         curMax_r <= cmd.lba; // RULE_02
      end
   end

   // Reported capacity kept in step with the limit, one past the last block
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         capacity_r <= NATIVE_MAX + LBA_W'(1);
      end else if (limitReload) begin
         capacity_r <= nvMax_r + LBA_W'(1); // RULE_05
      end else if (acceptAddr) begin
         capacity_r <= cmd.lba + LBA_W'(1); // RULE_05
      end
   end

   // Response strobe, one cycle after each limit command
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rspValid_r <= 1'b0;
      end else begin
         rspValid_r <= isNative || isSetMax;
      end
   end

   // Response status
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rspErr_r <= ERR_NONE;
      end else if (isSetMax && !allowed) begin
         rspErr_r <= ERR_ABORT; // RULE_13
      end else if (lbaRefused) begin
         rspErr_r <= ERR_IDNF;
      end else begin
         rspErr_r <= ERR_NONE;
      end
   end

   // Response address; other accepted sub-functions echo the current limit
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rspLba_r <= '0;
      end else if (isNative) begin
         rspLba_r <= NATIVE_MAX; // RULE_01
      end else if (acceptAddr) begin
         rspLba_r <= cmd.lba;
      end else if (isSetMax && allowed && !lbaRefused) begin
         rspLba_r <= curMax_r;
      end else begin
         rspLba_r <= '0;
      end
   end

   hpa_range_check #(
      .LW(LBA_W)
   ) uRange (
      .startLba(acc.lba),
      .count(acc.count),
      .maxLba(curMax_r),
      .outOfRange(outOfRange)
   );

   // Media access gate; a software reset only clears these strobes
   always_ff @(posedge core_clk) begin
      if (accClear) begin
         accGrant_r <= 1'b0;
         accReject_r <= 1'b0;
      end else begin
         accGrant_r <= accValid && !outOfRange; // RULE_03
         accReject_r <= accValid && outOfRange; // RULE_14
      end
   end

   assign rspValid = rspValid_r;
   assign rsp = '{err: rspErr_r, lba: rspLba_r};
   assign accGrant = accGrant_r;
   assign accReject = accReject_r;
   assign curMax = curMax_r;
   assign idCapacity = capacity_r; // RULE_05
   assign lockState = lock_r;
   assign nvWrite = nvWrite_r;
   assign nvData = nvMax_r;

   always_comb begin
      idWord83 = 16'h0000;
      idWord86 = 16'h0000;
      idWord83[ID_EXT_BIT] = 1'b1; // RULE_11
      idWord86[ID_EXT_BIT] = extEnabled_r; // RULE_11
   end
endmodule
`default_nettype wire

// ==== test/hpa_ctrl_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module hpa_ctrl_assertions
   import hpa_pkg::*;
#(
   parameter logic [LBA_W-1:0] NATIVE_MAX = NATIVE_MAX_DEF
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic powerOn,
   input wire logic hardReset,
   input wire logic softReset,
   input wire logic cmdValid,
   input wire hpa_pkg::hpa_cmd_s cmd,
   input wire logic accValid,
   input wire hpa_pkg::hpa_acc_s acc,
   input wire hpa_pkg::hpa_rsp_s rsp,
   input wire logic accGrant,
   input wire logic accReject,
   input wire logic [LBA_W-1:0] curMax,
   input wire logic [LBA_W-1:0] idCapacity,
   input wire logic [15:0] idWord83,
   input wire logic [1:0] lockState
);
   import hpa_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire quiet = !powerOn && !hardReset;
   wire setCmd = quiet && cmdValid && cmd.opcode == CMD_SET_MAX;
   sequence aborted;
      rsp.err == ERR_ABORT && $stable(curMax);
   endsequence
   native_read_a: assert property (
      quiet && cmdValid && cmd.opcode == CMD_READ_NATIVE |=> rsp.lba == NATIVE_MAX)
      else $error("bad native read");
   set_addr_a: assert property (
      setCmd && cmd.sub == SUB_SET_ADDR && !lockState[1] && cmd.lba <= NATIVE_MAX
      |=> curMax == $past(cmd.lba)) else $error("limit not set");
   cap_follow_a: assert property (idCapacity == curMax + 48'h1)
      else $error("bad capacity");
   ext_support_a: assert property (idWord83[ID_EXT_BIT])
      else $error("support bit clear");
   frozen_hold_a: assert property (
      lockState == HPA_FROZEN && quiet |=> lockState == HPA_FROZEN) else $error("thawed");
   frozen_abort_a: assert property (setCmd && lockState == HPA_FROZEN |=> aborted)
      else $error("frozen not aborted");
   locked_abort_a: assert property (
      setCmd && lockState == HPA_LOCKED && cmd.sub != SUB_UNLOCK |=> aborted)
      else $error("locked not aborted");
   range_reject_a: assert property (
      quiet && !softReset && accValid && acc.lba > curMax |=> accReject && !accGrant)
      else $error("range not rejected");
   pwd_keep_a: assert property (!powerOn && !cmdValid |=> $stable(lockState))
      else $error("lock state lost");
endmodule
`default_nettype wire

// ==== test/hpa_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module hpa_host_model
   import hpa_pkg::*;
(
   input wire logic core_clk,
   output logic cmdValid,
   output hpa_pkg::hpa_cmd_s cmd,
   output logic accValid,
   output hpa_pkg::hpa_acc_s acc,
   input wire hpa_pkg::hpa_rsp_s rsp,
   input wire logic accGrant,
   input wire logic accReject
);
   import hpa_pkg::*;
   hpa_rsp_s gotRsp;
   logic [1:0] gotAcc;
   initial begin
      cmdValid = 1'b0;
      accValid = 1'b0;
      cmd = '0;
      acc = '0;
   end
   task automatic doCmd(input logic [7:0] op, input logic [2:0] sb, input logic vol,
         input logic [LBA_W-1:0] a, input logic [PWD_W-1:0] pw);
      @(posedge core_clk);
      #1 cmd = '{op, sb, vol, a, pw};
      cmdValid = 1'b1;
      @(posedge core_clk);
      #1 gotRsp = rsp;
      cmdValid = 1'b0;
      // Released lines must not keep the last value
      cmd = ~cmd;
   endtask
   task automatic doAcc(input logic [LBA_W-1:0] a, input logic [15:0] n);
      @(posedge core_clk);
      #1 acc = '{a, n, 1'b0};
      accValid = 1'b1;
      @(posedge core_clk);
      #1 gotAcc = {accGrant, accReject};
      accValid = 1'b0;
      acc = ~acc;
   endtask
endmodule
`default_nettype wire

// ==== test/tb_hpa_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_hpa_ctrl;
   import hpa_pkg::*;
   localparam logic [LBA_W-1:0] NM = NATIVE_MAX_DEF;
   localparam logic [LBA_W-1:0] LIM = 48'h0000_00BB_85FF;
   localparam logic [PWD_W-1:0] PW = 32'h5A3C_96E1;
   logic core_clk, rst_n, powerOn, hardReset, softReset, cmdValid, accValid;
   logic rspValid, accGrant, accReject, nvWrite;
   hpa_cmd_s cmd;
   hpa_acc_s acc;
   hpa_rsp_s rsp;
   logic [LBA_W-1:0] curMax, idCapacity, nvData;
   logic [15:0] idWord83, idWord86;
   logic [1:0] lockState;
   int failures = 0;
   int checked = 0;
   hpa_ctrl dut (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .powerOn(powerOn),
      .hardReset(hardReset),
      .softReset(softReset),
      .cmdValid(cmdValid),
      .cmd(cmd),
      .accValid(accValid),
      .acc(acc),
      .rspValid(rspValid),
      .rsp(rsp),
      .accGrant(accGrant),
      .accReject(accReject),
      .curMax(curMax),
      .idCapacity(idCapacity),
      .idWord83(idWord83),
      .idWord86(idWord86),
      .lockState(lockState),
      .nvWrite(nvWrite),
      .nvData(nvData)
   );
   hpa_host_model host (
      .core_clk(core_clk),
      .cmdValid(cmdValid),
      .cmd(cmd),
      .accValid(accValid),
      .acc(acc),
      .rsp(rsp),
      .accGrant(accGrant),
      .accReject(accReject)
   );
   task automatic chk(input logic [LBA_W-1:0] g, input logic [LBA_W-1:0] e);
      checked++;
      if (g !== e) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, g, e);
      end
   endtask
   task automatic pulse(ref logic s);
      @(posedge core_clk);
      #1 s = 1'b1;
      @(posedge core_clk);
      #1 s = 1'b0;
   endtask
   task automatic tLimit();
      host.doCmd(CMD_SET_MAX, SUB_SET_ADDR, 1'b0, LIM, '0);
      chk(curMax, LIM);
      chk(idCapacity, LIM + 1);
      chk(nvWrite, 1'b1);
      chk(nvData, LIM);
      chk(rspValid, 1'b1);
      chk(host.gotRsp.lba, LIM);
      host.doCmd(CMD_SET_MAX, 3'h5, 1'b0, NM, '0);
      chk(host.gotRsp.err, ERR_ABORT);
      chk(curMax, LIM);
      host.doCmd(CMD_READ_NATIVE, SUB_SET_ADDR, 1'b0, '0, '0);
      chk(rspValid, 1'b1);
      chk(host.gotRsp.lba, NM);
      host.doAcc(LIM, 16'h0001);
      chk(host.gotAcc, 2'b10);
      host.doAcc(LIM, 16'h0002);
      chk(host.gotAcc, 2'b01);
      host.doCmd(CMD_SET_MAX, SUB_SET_ADDR, 1'b0, NM + 1, '0);
      chk(host.gotRsp.err, ERR_IDNF);
      chk(curMax, LIM);
   endtask
   task automatic tVolatile();
      host.doCmd(CMD_SET_MAX, SUB_SET_ADDR, 1'b1, NM, '0);
      chk(nvWrite, 1'b0);
      chk(nvData, LIM);
      chk(curMax, NM);
      host.doAcc(LIM + 1, 16'h0001);
      chk(host.gotAcc, 2'b10);
      pulse(hardReset);
      chk(curMax, LIM);
      host.doAcc(LIM + 1, 16'h0001);
      chk(host.gotAcc, 2'b01);
   endtask
   task automatic tLock();
      host.doCmd(CMD_SET_MAX, SUB_SET_PWD, 1'b0, '0, PW);
      chk(lockState, HPA_UNLOCKED);
      chk(idWord86[ID_EXT_BIT], 1'b1);
      host.doCmd(CMD_SET_MAX, SUB_LOCK, 1'b0, '0, '0);
      chk(lockState, HPA_LOCKED);
      host.doCmd(CMD_SET_MAX, SUB_SET_ADDR, 1'b0, NM, '0);
      chk(host.gotRsp.err, ERR_ABORT);
      chk(curMax, LIM);
      pulse(hardReset);
      pulse(softReset);
      chk(lockState, HPA_LOCKED);
      host.doCmd(CMD_SET_MAX, SUB_UNLOCK, 1'b0, '0, ~PW);
      chk(lockState, HPA_LOCKED);
      host.doCmd(CMD_SET_MAX, SUB_UNLOCK, 1'b0, '0, PW);
      chk(lockState, HPA_UNLOCKED);
   endtask
   task automatic tFreeze();
      host.doCmd(CMD_SET_MAX, SUB_FREEZE, 1'b0, '0, '0);
      chk(lockState, HPA_FROZEN);
      host.doCmd(CMD_SET_MAX, SUB_UNLOCK, 1'b0, '0, PW);
      chk(host.gotRsp.err, ERR_ABORT);
      pulse(powerOn);
      chk(lockState, HPA_NOPWD);
      chk(curMax, LIM);
   endtask
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial begin
      #100000;
      failures++;
      report_and_stop();
   end
   initial begin
      rst_n = 1'b0;
      powerOn = 1'b0;
      hardReset = 1'b0;
      softReset = 1'b0;
      repeat (10) @(posedge core_clk);
      #1 rst_n = 1'b1;
      tLimit();
      tVolatile();
      tLock();
      tFreeze();
      report_and_stop();
   end
endmodule
bind hpa_ctrl hpa_ctrl_assertions #(.NATIVE_MAX(NATIVE_MAX)) chk_i (
   .core_clk(core_clk),
   .rst_n(rst_n),
   .powerOn(powerOn),
   .hardReset(hardReset),
   .softReset(softReset),
   .cmdValid(cmdValid),
   .cmd(cmd),
   .accValid(accValid),
   .acc(acc),
   .rsp(rsp),
   .accGrant(accGrant),
   .accReject(accReject),
   .curMax(curMax),
   .idCapacity(idCapacity),
   .idWord83(idWord83),
   .lockState(lockState)
);
`default_nettype wire
